// [core/megl_pkg.sv]
// Shared constants and carrier types for the expansion bus glue
package megl_pkg;

  // ----------------------------------------------------------------
  // Requesters on the expansion bus
  // ----------------------------------------------------------------
  localparam int NUM_REPEATERS = 2;

  // ----------------------------------------------------------------
  // Backoff counter: seven bits, 96 bit times to terminal count
  // ----------------------------------------------------------------
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] CNT_TERMINAL = 7'h60;
  localparam logic [CNT_W-1:0] CNT_CLEARED = 7'h00;
  localparam logic [CNT_W-1:0] CNT_STEP = 7'h01;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int BUS_CYCLE_NS = 100;
  localparam int DEAD_CYCLES = (BUS_CYCLE_NS + CLK_PERIOD_NS - 1) /
                               CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic grant;
    logic multi_request;
  } megl_arb_t;

  typedef struct packed {
    logic serial_out;
    logic serial_oe;
    logic clash_out;
    logic clash_oe;
  } megl_lines_t;

  typedef struct packed {
    logic carrier_sense;
    logic receive_clock;
    logic tx_clock;
  } megl_mac_t;

endpackage

// [core/megl_glue.sv]
// Arbiter, bus interface and backoff counter joining a MAC to the bus
// What this block does
// - Grant while exactly one of repeater and MAC requests is active, or in the MAC tail.
// - Multi-request flag when no grant but at least one request active.
// - Grant held one extra term after the MAC stops sourcing data.
// - Grant delayed one clock; both high marks first valid line period.
// - Backoff hold set on arbiter clash, clash line during valid grant at any serial level, dead cycle.
// - Backoff hold stays, refusing MAC, until counter reaches 96.
// - Clash state on both lines high, multi-request or dead cycle.
// - Retrigger on new packet without backoff, new single or multi clash.
// - Request delayed one clock; both high mark first recognised request.
// - Line drivers enabled only when MAC won grant and grant delayed.
// - Driven serial line carries resampled MAC bit, held across the clock.
// - Driven serial line forced high while backoff hold is active.
// - Driven clash line equals the backoff hold.
// - Carrier sense on single clean source, extended by receive clock gate.
// - Resampled bit takes bus data or MAC transmit data by request.
// - Receive clock output is the registered gate strobe; the board ANDs it with inverted clock.
// - Receive gate on for repeater transfers, and MAC transmit loopback.
// - Reset loads counter with terminal value 60H and holds it.
// - Each retrigger clears the counter to 00H.
// - Counter steps once per bit time, halts at terminal, flags expiry.
// - Asynchronous reset input is synchronised before use.
// - Transmit timing clock made from system clock, held during reset.
// - One undriven 100 ns bus cycle when multi clash resolves to one.
`timescale 1ns/1ps
module megl_glue (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic ASYNC_RESET_IN,
  input wire logic [megl_pkg::NUM_REPEATERS-1:0] REPEATER_REQ,
  input wire logic MAC_SEND_REQ,
  input wire logic MAC_TXD,
  input wire logic EXPANSION_SERIAL_LINE_IN,
  input wire logic BUS_CLASH_LINE_IN,
  output logic GRANT,
  output logic MULTI_REQUEST,
  output logic EXPANSION_SERIAL_LINE_OUT,
  output logic EXPANSION_SERIAL_LINE_OE,
  output logic BUS_CLASH_LINE_OUT,
  output logic BUS_CLASH_LINE_OE,
  output logic MAC_CARRIER_SENSE,
  output logic MAC_RECEIVE_CLOCK,
  output logic MAC_TX_CLOCK,
  output logic MAC_BACKOFF_HOLD
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic async_reset_in_meta_r;
  logic async_reset_in_sync_r;
  logic rst_r;

  always_ff @(posedge CLK) begin
    async_reset_in_meta_r <= ASYNC_RESET_IN;
    async_reset_in_sync_r <= async_reset_in_meta_r;
  end

  // Either reset source ends up in one registered reset
  always_ff @(posedge CLK) begin
    rst_r <= async_reset_in_sync_r | ~RST_N;
  end

  // ----------------------------------------------------------------
  // Arbiter
  // ----------------------------------------------------------------
  // Bus lines and requests share the common clock, so no sampling flops
  logic [megl_pkg::NUM_REPEATERS:0] all_req;
  logic one_active;
  logic any_active;
  logic mac_tail;
  megl_pkg::megl_arb_t arb_nxt;
  megl_pkg::megl_arb_t arb_r;
  logic grant_delayed_r;
  logic multi_request_delayed_r;
  logic send_request_delayed_r;
  logic mac_backoff_hold_r;
  logic transmit_clash_state_r;
  logic window_retrigger_r;
  logic window_expired;

  assign all_req = {MAC_SEND_REQ, REPEATER_REQ};
  assign one_active = $onehot(all_req);
  assign any_active = |all_req;
  // Keeps the grant while the MAC lets go, unless a clash is pending
  assign mac_tail = ~any_active & send_request_delayed_r &
                    grant_delayed_r & ~mac_backoff_hold_r;
  assign arb_nxt.grant = one_active | mac_tail;
  assign arb_nxt.multi_request = ~arb_nxt.grant & any_active;

  always_ff @(posedge CLK) begin
    if (rst_r) begin
      arb_r <= '0;
      grant_delayed_r <= 1'b0;
      multi_request_delayed_r <= 1'b0;
      send_request_delayed_r <= 1'b0;
    end else begin
      arb_r <= arb_nxt;
      grant_delayed_r <= arb_r.grant;
      multi_request_delayed_r <= arb_r.multi_request;
      send_request_delayed_r <= MAC_SEND_REQ;
    end
  end

  // ----------------------------------------------------------------
  // Clash tracking
  // ----------------------------------------------------------------
  logic grant_valid;
  logic dead_cycle;
  logic single_clash;
  logic hold_nxt;
  logic clash_nxt;
  logic retrigger_nxt;

  assign grant_valid = arb_r.grant & grant_delayed_r;
  // Grant back after a multi clash: lines stay undriven, clash persists
  assign dead_cycle = multi_request_delayed_r & arb_r.grant;
  // Clash line plus high serial line means one repeater port clashes
  assign single_clash = grant_valid & BUS_CLASH_LINE_IN &
                        EXPANSION_SERIAL_LINE_IN;
  assign hold_nxt = arb_r.multi_request |
                    (grant_valid & BUS_CLASH_LINE_IN) | dead_cycle |
                    (~window_expired & mac_backoff_hold_r);
  assign clash_nxt = single_clash | arb_r.multi_request |
                     dead_cycle;
  assign retrigger_nxt =
    (arb_r.grant & ~grant_delayed_r & ~mac_backoff_hold_r) |
    (single_clash & ~transmit_clash_state_r) |
    (arb_r.multi_request & ~transmit_clash_state_r);

  always_ff @(posedge CLK) begin
    if (rst_r) begin
      mac_backoff_hold_r <= 1'b0;
      transmit_clash_state_r <= 1'b0;
      window_retrigger_r <= 1'b0;
    end else begin
      mac_backoff_hold_r <= hold_nxt;
      transmit_clash_state_r <= clash_nxt;
      window_retrigger_r <= retrigger_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Bus interface and MAC side
  // ----------------------------------------------------------------
  logic resampled_serial_bit_r;
  logic receive_clock_gate_r;
  logic resample_nxt;
  logic gate_nxt;
  logic sense_nxt;
  logic drive_en;
  megl_pkg::megl_lines_t lines_nxt;
  megl_pkg::megl_lines_t lines_r;
  megl_pkg::megl_mac_t mac_nxt;
  megl_pkg::megl_mac_t mac_r;
  logic tck_r;

  assign resample_nxt =
    (~MAC_SEND_REQ & EXPANSION_SERIAL_LINE_IN & grant_valid) |
    (MAC_TXD & MAC_SEND_REQ);
  assign gate_nxt =
    (grant_valid & ~MAC_SEND_REQ & ~send_request_delayed_r &
     ~BUS_CLASH_LINE_IN) |
    (arb_r.grant & MAC_SEND_REQ & ~mac_backoff_hold_r);
  assign sense_nxt = (grant_valid & ~BUS_CLASH_LINE_IN &
                      ~mac_backoff_hold_r) | receive_clock_gate_r;
  assign drive_en = grant_valid & send_request_delayed_r;
  assign lines_nxt.serial_oe = drive_en;
  // Registered copy of the resampled bit gives slaves a full cycle of hold
  assign lines_nxt.serial_out = resampled_serial_bit_r |
                                mac_backoff_hold_r;
  assign lines_nxt.clash_oe = drive_en;
  assign lines_nxt.clash_out = mac_backoff_hold_r;
  assign mac_nxt.carrier_sense = sense_nxt;
  // One clock domain: this is a strobe the board ANDs with inverted CLK
  assign mac_nxt.receive_clock = receive_clock_gate_r;
  assign mac_nxt.tx_clock = ~tck_r;

  always_ff @(posedge CLK) begin
    if (rst_r) begin
      resampled_serial_bit_r <= 1'b0;
      receive_clock_gate_r <= 1'b0;
      lines_r <= '0;
      mac_r <= '0;
      tck_r <= 1'b0;
    end else begin
      resampled_serial_bit_r <= resample_nxt;
      receive_clock_gate_r <= gate_nxt;
      lines_r <= lines_nxt;
      mac_r <= mac_nxt;
      tck_r <= ~tck_r;
    end
  end

  // ----------------------------------------------------------------
  // Backoff counter
  // ----------------------------------------------------------------
  logic [megl_pkg::CNT_W-1:0] cnt_r;
  logic [megl_pkg::CNT_W-1:0] cnt_nxt;

  assign window_expired = (cnt_r == megl_pkg::CNT_TERMINAL);
  assign cnt_nxt = window_retrigger_r ? megl_pkg::CNT_CLEARED :
                   window_expired ? cnt_r :
                   cnt_r + megl_pkg::CNT_STEP;

  always_ff @(posedge CLK) begin
    if (rst_r) begin
      cnt_r <= megl_pkg::CNT_TERMINAL;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign GRANT = arb_r.grant;
  assign MULTI_REQUEST = arb_r.multi_request;
  assign EXPANSION_SERIAL_LINE_OUT = lines_r.serial_out;
  assign EXPANSION_SERIAL_LINE_OE = lines_r.serial_oe;
  assign BUS_CLASH_LINE_OUT = lines_r.clash_out;
  assign BUS_CLASH_LINE_OE = lines_r.clash_oe;
  assign MAC_CARRIER_SENSE = mac_r.carrier_sense;
  assign MAC_RECEIVE_CLOCK = mac_r.receive_clock;
  assign MAC_TX_CLOCK = mac_r.tx_clock;
  assign MAC_BACKOFF_HOLD = mac_backoff_hold_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (rst_r);

  sequence multi_then_grant_s;
    arb_r.multi_request ##1 arb_r.grant;
  endsequence

  sequence counting_s;
    ~window_expired && ~window_retrigger_r;
  endsequence

  grant_single_a: assert property (
    one_active |=> arb_r.grant)
    else $error("grant missing with one request");

  grant_only_one_a: assert property (
    arb_r.grant |-> $past(one_active || mac_tail))
    else $error("grant without single requester");

  multi_flag_a: assert property (
    (any_active && !one_active && !mac_tail) |=> arb_r.multi_request)
    else $error("multi-request flag missing");

  grant_delay_a: assert property (
    arb_r.grant |=> grant_delayed_r)
    else $error("delayed grant not following grant");

  dead_cycle_hold_a: assert property (
    multi_then_grant_s |=> mac_backoff_hold_r && transmit_clash_state_r)
    else $error("clash lost in dead cycle");

  hold_keep_a: assert property (
    mac_backoff_hold_r && !window_expired |=> mac_backoff_hold_r)
    else $error("backoff hold dropped before expiry");

  send_delay_a: assert property (
    MAC_SEND_REQ |=> send_request_delayed_r)
    else $error("delayed send request missing");

  drive_enable_a: assert property (
    EXPANSION_SERIAL_LINE_OE |->
      $past(arb_r.grant && grant_delayed_r && send_request_delayed_r))
    else $error("lines driven without valid grant");

  serial_force_a: assert property (
    mac_backoff_hold_r && !rst_r |=> EXPANSION_SERIAL_LINE_OUT)
    else $error("serial line not forced high");

  retrigger_clear_a: assert property (
    window_retrigger_r |=> cnt_r == megl_pkg::CNT_CLEARED)
    else $error("retrigger did not clear counter");

  count_step_a: assert property (
    counting_s |=> cnt_r == $past(cnt_r) + megl_pkg::CNT_STEP)
    else $error("counter failed to step");

  count_halt_a: assert property (
    window_expired && !window_retrigger_r |=> window_expired)
    else $error("counter left terminal value");

  clash_follow_a: assert property (
    mac_backoff_hold_r |=> BUS_CLASH_LINE_OUT)
    else $error("clash line not following backoff hold");

  gate_loop_a: assert property (
    arb_r.grant && MAC_SEND_REQ && !mac_backoff_hold_r |=> receive_clock_gate_r)
    else $error("receive gate missing on transmit loopback");

endmodule

// [sim/megl_rep_model.sv]
// Repeater chips sharing the expansion bus with the glue
`timescale 1ns/1ps
module megl_rep_model (
  input wire logic clk,
  input wire logic [1:0] want,
  input wire logic jam_cmd,
  input wire logic one_port,
  input wire logic data_bit,
  input wire logic grant,
  input wire logic multi_request,
  input wire megl_pkg::megl_lines_t glue,
  output logic [1:0] rep_req,
  output logic serial_line,
  output logic clash_line
);
  // ------
  // Line ownership
  // ------
  logic dead_r = 1'b0;
  logic idle_r = 1'b0;
  logic rep_drive;
  assign rep_req = want;
  // Silent in the cycle that follows a multi-request clash
  assign rep_drive = grant && !dead_r &&
                     (want == 2'b01 || want == 2'b10);
  always_ff @(posedge clk) begin
    dead_r <= multi_request;
    idle_r <= ~idle_r;
  end
  // Released serial line toggles so a stale level is never trusted
  assign serial_line = glue.serial_oe ? glue.serial_out :
    rep_drive ? (jam_cmd ? one_port : data_bit) : idle_r;
  // Clash line is pulled low, so an idle bus never reads as a jam
  assign clash_line = glue.clash_oe ? glue.clash_out : rep_drive & jam_cmd;
endmodule

// [sim/megl_glue_test.sv]
// Self-checking bench for the expansion bus glue
`timescale 1ns/1ps
module megl_glue_test;
  // ------
  // Signals
  // ------
  localparam logic [9:0] G = 10'h200, MU = 10'h100, SOE = 10'h080;
  localparam logic [9:0] SO = 10'h040, COE = 10'h020, CO = 10'h010;
  localparam logic [9:0] H = 10'h008, CR = 10'h004, RX = 10'h002;
  localparam logic [9:0] JM = G | SOE | SO | COE | CO | H;
  localparam logic [9:0] TXM = 10'h3FE, RSTM = 10'h3BF;
  localparam logic [9:0] RPM = G | SOE | COE | H | CR | RX;
  logic CLK, RST_N, async_reset_in, mac, txd, jam, one, rdat;
  logic [1:0] rq, th;
  logic [2:0] d;
  logic [megl_pkg::NUM_REPEATERS-1:0] rreq;
  logic grant, multi, s_out, s_oe, c_out, c_oe, mac_carrier_sense, mac_receive_clock, txc, hold;
  logic s_line, c_line;
  logic [9:0] obs, m, e;
  logic [9:0] q_m[$];
  logic [9:0] q_e[$];
  logic [31:0] seed = 32'h36;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  megl_pkg::megl_lines_t lines;
  assign lines = {s_out, s_oe, c_out, c_oe};
  assign obs = {grant, multi, s_oe, s_out, c_oe, c_out, hold, mac_carrier_sense, mac_receive_clock,
                txc};
  megl_glue u_dut (.CLK(CLK), .RST_N(RST_N), .ASYNC_RESET_IN(async_reset_in),
    .REPEATER_REQ(rreq), .MAC_SEND_REQ(mac), .MAC_TXD(txd),
    .EXPANSION_SERIAL_LINE_IN(s_line), .BUS_CLASH_LINE_IN(c_line),
    .GRANT(grant), .MULTI_REQUEST(multi),
    .EXPANSION_SERIAL_LINE_OUT(s_out), .EXPANSION_SERIAL_LINE_OE(s_oe),
    .BUS_CLASH_LINE_OUT(c_out), .BUS_CLASH_LINE_OE(c_oe),
    .MAC_CARRIER_SENSE(mac_carrier_sense), .MAC_RECEIVE_CLOCK(mac_receive_clock),
    .MAC_TX_CLOCK(txc), .MAC_BACKOFF_HOLD(hold));
  megl_rep_model u_rep (.clk(CLK), .want(rq), .jam_cmd(jam),
    .one_port(one), .data_bit(rdat), .grant(grant),
    .multi_request(multi), .glue(lines), .rep_req(rreq),
    .serial_line(s_line), .clash_line(c_line));
  // ------
  // Helpers
  // ------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Serial output expectation comes from the bit sent two cycles earlier
  task automatic step(input logic [2:0] dd, input logic [9:0] mm,
                      input logic [9:0] ee);
    @(negedge CLK);
    {mac, rq} = dd;
    th = {th[0], txd};
    seed = xs(seed);
    txd = seed[0];
    rdat = seed[1];
    ee[6] = ee[6] | th[1];
    q_m.push_back(mm);
    q_e.push_back(ee);
  endtask
  task automatic wait_hold(input logic v);
    int n;
    n = 0;
    while (hold !== v && n < 300) begin
      step(3'h0, 10'h000, 10'h000);
      n++;
    end
    step(3'h0, H, {6'h00, v, 3'h0});
  endtask
  // ------
  // Clock, timeout, monitor
  // ------
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      give_verdict();
    end
  end
  always @(negedge CLK) begin
    #1;
    if (q_m.size() > 0) begin
      m = q_m.pop_front();
      e = q_e.pop_front();
      if (m != 10'h000) begin
        n_compared++;
        if ((obs & m) !== (e & m)) begin
          err_count++;
          $display("[FAIL] %0t: outputs %b, expected %b under %b",
                   $time, obs, e, m);
        end
      end
    end
  end
  // ------
  // Scenarios
  // ------
  initial begin
    {RST_N, async_reset_in, mac, txd, jam, one, rdat, rq, th} = '0;
    repeat (10) @(negedge CLK);
    step(3'h0, RSTM, 10'h000);
    RST_N = 1'b1;
    step(3'h0, RSTM, 10'h000);
    step(3'h0, 10'h001, 10'h001);
    for (int k = 0; k < 16; k++) begin
      d = (k < 8) ? k[2:0] : seed[4:2];
      repeat (2) step(d, 10'h000, 10'h000);
      step(d, G | MU,
           {$countones(d) == 1, $countones(d) > 1, 8'h00});
    end
    wait_hold(1'b0);
    for (int i = 0; i < 105; i++) begin
      step((i < 2) ? 3'h5 : 3'h0, (i == 96 || i == 104) ? H : 10'h000,
           (i == 96) ? H : 10'h000);
    end
    for (int i = 0; i < 10; i++) begin
      step((i < 2) ? 3'h5 : 3'h4, (i > 6) ? JM : 10'h000, JM);
    end
    wait_hold(1'b0);
    for (int i = 0; i < 14; i++) begin
      step(3'h4, (i > 4) ? TXM : 10'h000,
           G | SOE | COE | CR | RX);
    end
    step(3'h0, G, G);
    step(3'h0, G | SOE, G | SOE);
    step(3'h0, G | SOE, 10'h000);
    for (int i = 0; i < 12; i++) begin
      jam = (i > 5);
      one = jam;
      step(3'h1, (i == 5 || i == 11) ? RPM : 10'h000,
           (i == 5) ? (G | CR | RX) : (G | H));
    end
    async_reset_in = 1'b1;
    for (int i = 0; i < 6; i++) begin
      step(3'h0, (i == 5) ? RSTM : 10'h000, 10'h000);
    end
    async_reset_in = 1'b0;
    jam = 1'b0;
    repeat (4) step(3'h0, 10'h000, 10'h000);
    step(3'h0, H, 10'h000);
    step(3'h0, 10'h000, 10'h000);
    give_verdict();
  end
endmodule
